// *** src/smf_pkg.sv ***
// Shared constants, types and helpers for the mode-fault and request logic
package smf_pkg;

  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_BIT1 = 4'h7;
  localparam logic [3:0] CNT_BYTE = 4'h8;
  localparam logic [2:0] MSB_INDEX = 3'h7;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    SMF_XF_IDLE = 3'b001,
    SMF_XF_BUSY = 3'b010,
    SMF_XF_TAIL = 3'b100
  } smf_xfer_t;

  // Software-side controls
  typedef struct packed {
    logic masterRoleSelect;
    logic clockPhaseSelect;
    logic clockPolarity;
    logic roleConflictDetectEnable;
    logic errorIrqEnable;
    logic rxIrqEnable;
    logic txIrqEnable;
  } smf_ctrl_t;

  // Register access strobes
  typedef struct packed {
    logic statusRead;
    logic ctrlWrite;
    logic ctrlWriteOn;
    logic dataRead;
    logic dataWrite;
    logic [7:0] dataWriteByte;
  } smf_access_t;

  // Flags seen by software
  typedef struct packed {
    logic serialPortOn;
    logic txEmptyFlag;
    logic rxFullFlag;
    logic rxOverrunFlag;
    logic roleConflictFlag;
  } smf_status_t;

  typedef struct packed {
    smf_xfer_t xfer;
    logic spOn;
    logic txEmpty;
    logic rxFull;
    logic ovr;
    logic conf;
    logic confArm;
    logic confHit;
    logic ovrArm;
    logic discard;
    logic ssPrev;
    logic stateClr;
    logic [3:0] cntPrev;
    logic [7:0] txBuf;
    logic [7:0] shiftSrc;
    logic [7:0] rxData;
  } smf_state_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic [3:0] cntGray;
    logic [7:0] rxShift;
  } smf_link_t;

  function automatic logic [3:0] nextCount(input logic [3:0] c);
    nextCount = (c == CNT_BYTE) ? CNT_ONE : 4'(c + CNT_ONE);
  endfunction

  function automatic logic [3:0] toGray(input logic [3:0] b);
    toGray = b ^ (b >> 1);
  endfunction

  function automatic logic [3:0] fromGray(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    b[2] = b[3] ^ g[2];
    b[1] = b[2] ^ g[1];
    b[0] = b[1] ^ g[0];
    fromGray = b;
  endfunction

endpackage

// *** src/smf_sync.sv ***
// Two-flop synchroniser for levels and gray-coded words
`timescale 1ns/1ps
`default_nettype none
module smf_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** src/smf_link.sv ***
// Slave capture logic clocked by the incoming serial clock
`timescale 1ns/1ps
`default_nettype none
module smf_link (
  input wire logic captureClk,
  input wire logic linkRst,
  input wire logic mosi,
  output smf_pkg::smf_link_t link
);
  smf_pkg::smf_link_t link_d;
  smf_pkg::smf_link_t link_q;

  always_comb begin
    link_d = link_q;
    link_d.cnt = smf_pkg::nextCount(link_q.cnt);
    link_d.cntGray = smf_pkg::toGray(link_d.cnt);
    link_d.rxShift = {link_q.rxShift[6:0], mosi};
  end

  // Deselect holds the counter cleared, so edges while deselected do nothing
  always_ff @(posedge captureClk or posedge linkRst) begin
    if (linkRst) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  assign link = link_q;
endmodule
`default_nettype wire

// *** src/smf_core.sv ***
// Mode-fault detection, status flags and CPU request generation
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Conflict flag sets only while detect enable is 1; clearing enable keeps flag.
// - Receive-full, overrun and conflict share one receiver/error request output.
// - One error enable gates overrun and conflict together; no per-flag enable.
// - Master with detect enable sets conflict flag when select input is low.
// - Master conflict clears port enable, sets tx empty, clears counter, releases pins.
// - Setting the conflict flag never alters the master role selection.
// - Slave sets conflict flag when select rises during a transfer.
// - Phase 0 slave transfer starts at select fall, ends at idle after bit 8.
// - Phase 1 slave transfer starts when clock leaves idle with select low.
// - Phase 0 select then deselect without clocks still raises a conflict.
// - Phase 1 select then deselect without clocks raises no conflict.
// - Slave conflict raises request if enabled; port enable and logic untouched.
// - Deselected slave floats its data output and ignores all serial clocks.
// - Flag clears on status read then control write, only with no fault meanwhile.
// - Transmitter request while tx empty and tx request enable are set.
// - Receive-full request needs rx request enable and port enable.
// - Overrun request needs rx request enable and error enable.
// - Conflict request needs rx enable, error enable and detect enable.
// - Receive-full sets whenever a byte moves into the receive data register.
// - Tx empty sets whenever a byte moves from transmit buffer to shifter.
// - Overrun sets if receive data unread at bit 7 capture; new byte dropped.
module smf_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire smf_pkg::smf_ctrl_t ctrl,
  input wire smf_pkg::smf_access_t access,
  input wire logic slaveSelectN,
  input wire logic serialClockPin,
  input wire logic mosi,
  output logic misoOut,
  output logic misoOeN,
  output smf_pkg::smf_status_t status,
  output logic [7:0] rxData,
  output logic spiOwnsPins,
  output logic stateCounterClear,
  output logic txIrq,
  output logic rxErrIrq
);
  smf_pkg::smf_state_t s_d;
  smf_pkg::smf_state_t s_q;
  smf_pkg::smf_link_t link;
  logic ssSync;
  logic ssActive;
  logic sclkSync;
  logic [3:0] cntGraySync;
  logic captureClk;
  logic linkRst;
  logic ssLow;
  logic ssRise;
  logic ssFall;
  logic sclkIdle;
  logic [3:0] cntNow;
  logic step;
  logic slaveOn;
  logic masterFault;
  logic slaveFault;
  logic fault;
  logic startXfer;

  // Capture edge is the rising edge of this clock for all four formats
  assign captureClk = serialClockPin ^ ctrl.clockPolarity ^ ctrl.clockPhaseSelect;
  assign linkRst = rst | slaveSelectN;
  assign ssSync = ~ssActive;

  smf_link u_link (
    .captureClk(captureClk),
    .linkRst(linkRst),
    .mosi(mosi),
    .link(link)
  );

  smf_sync #(.WIDTH(1)) u_ssSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn(~slaveSelectN),
    .syncOut(ssActive)
  );

  smf_sync #(.WIDTH(1)) u_sclkSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn(serialClockPin),
    .syncOut(sclkSync)
  );

  smf_sync #(.WIDTH(4)) u_cntSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn(link.cntGray),
    .syncOut(cntGraySync)
  );

  always_comb begin
    ssLow = ~ssSync;
    ssRise = ssSync & ~s_q.ssPrev;
    ssFall = ~ssSync & s_q.ssPrev;
    sclkIdle = (sclkSync == ctrl.clockPolarity);
    cntNow = smf_pkg::fromGray(cntGraySync);
    step = (cntNow != smf_pkg::CNT_ZERO) && (cntNow == smf_pkg::nextCount(s_q.cntPrev));
    slaveOn = s_q.spOn & ~ctrl.masterRoleSelect;
    masterFault = ctrl.roleConflictDetectEnable & ctrl.masterRoleSelect & ssLow;
    slaveFault = ctrl.roleConflictDetectEnable & ~ctrl.masterRoleSelect & ssRise
      & (s_q.xfer != smf_pkg::SMF_XF_IDLE);
    fault = masterFault | slaveFault;
    startXfer = 1'b0;

    s_d = s_q;
    s_d.ssPrev = ssSync;
    s_d.cntPrev = cntNow;
    s_d.stateClr = 1'b0;

    // Software accesses; hardware sets below take priority
    if (access.dataWrite) begin
      s_d.txBuf = access.dataWriteByte;
      s_d.txEmpty = 1'b0;
    end
    if (access.dataRead) begin
      s_d.rxFull = 1'b0;
      if (s_q.ovrArm) begin
        s_d.ovr = 1'b0;
      end
      s_d.ovrArm = 1'b0;
    end
    if (access.statusRead) begin
      s_d.ovrArm = s_q.ovr;
      s_d.confArm = s_q.conf;
      s_d.confHit = 1'b0;
    end
    if (access.ctrlWrite) begin
      s_d.spOn = access.ctrlWriteOn;
      if (s_q.confArm && !s_q.confHit && !fault) begin
        s_d.conf = 1'b0;
      end
      s_d.confArm = 1'b0;
    end

    // Slave transfer tracking
    unique case (s_q.xfer)
      smf_pkg::SMF_XF_IDLE: begin
        if (slaveOn && !ctrl.clockPhaseSelect && ssFall) begin
          startXfer = 1'b1;
        end
        if (slaveOn && ctrl.clockPhaseSelect && ssLow && !sclkIdle) begin
          startXfer = 1'b1;
        end
        if (startXfer) begin
          s_d.xfer = smf_pkg::SMF_XF_BUSY;
        end
      end
      smf_pkg::SMF_XF_BUSY: begin
        if (step && cntNow == smf_pkg::CNT_BYTE) begin
          s_d.xfer = smf_pkg::SMF_XF_TAIL;
        end
      end
      smf_pkg::SMF_XF_TAIL: begin
        if (sclkIdle) begin
          s_d.xfer = smf_pkg::SMF_XF_IDLE;
        end
      end
    endcase
    if (ssRise || !slaveOn) begin
      s_d.xfer = smf_pkg::SMF_XF_IDLE;
      s_d.discard = 1'b0;
    end

    // Load transmit byte into the shifter at transfer start
    if (startXfer && !s_q.txEmpty) begin
      s_d.shiftSrc = s_q.txBuf;
      s_d.txEmpty = 1'b1;
    end

    // Receive path
    if (slaveOn && step && cntNow == smf_pkg::CNT_BIT1 && s_q.rxFull) begin
      s_d.ovr = 1'b1;
      s_d.discard = 1'b1;
    end
    if (slaveOn && step && cntNow == smf_pkg::CNT_BYTE) begin
      if (!s_q.discard) begin
        s_d.rxData = link.rxShift;
        s_d.rxFull = 1'b1;
      end
      s_d.discard = 1'b0;
    end

    // Conflict handling; master role selection is never touched
    if (fault) begin
      s_d.conf = 1'b1;
      s_d.confHit = 1'b1;
    end
    if (masterFault) begin
      s_d.spOn = 1'b0;
      s_d.txEmpty = 1'b1;
      s_d.stateClr = 1'b1;
    end
    if (!s_q.spOn) begin
      s_d.txEmpty = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{xfer: smf_pkg::SMF_XF_IDLE, spOn: 1'b0, txEmpty: 1'b1, rxFull: 1'b0,
               ovr: 1'b0, conf: 1'b0, confArm: 1'b0, confHit: 1'b0, ovrArm: 1'b0,
               discard: 1'b0, ssPrev: 1'b1, stateClr: 1'b0, cntPrev: smf_pkg::CNT_ZERO,
               txBuf: smf_pkg::BYTE_RESET, shiftSrc: smf_pkg::BYTE_RESET,
               rxData: smf_pkg::BYTE_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  // Slave data output
  assign misoOut = s_q.shiftSrc[3'(smf_pkg::MSB_INDEX - link.cnt[2:0])];
  assign misoOeN = slaveSelectN | ctrl.masterRoleSelect | ~s_q.spOn;

  assign status.serialPortOn = s_q.spOn;
  assign status.txEmptyFlag = s_q.txEmpty;
  assign status.rxFullFlag = s_q.rxFull;
  assign status.rxOverrunFlag = s_q.ovr;
  assign status.roleConflictFlag = s_q.conf;
  assign rxData = s_q.rxData;
  assign spiOwnsPins = s_q.spOn;
  assign stateCounterClear = s_q.stateClr;

  // Request outputs
  assign txIrq = s_q.txEmpty & ctrl.txIrqEnable;
  assign rxErrIrq = (s_q.rxFull & ctrl.rxIrqEnable & s_q.spOn)
    | (s_q.ovr & ctrl.rxIrqEnable & ctrl.errorIrqEnable)
    | (s_q.conf & ctrl.rxIrqEnable & ctrl.errorIrqEnable
       & ctrl.roleConflictDetectEnable);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_FLAG_NEEDS_ENABLE: assert property (
    $rose(s_q.conf) |-> $past(ctrl.roleConflictDetectEnable))
    else $error("Conflict flag set with detect enable low");

  AST_MASTER_LOW_SELECT: assert property (
    ctrl.roleConflictDetectEnable && ctrl.masterRoleSelect && !ssSync |=> s_q.conf)
    else $error("Master low select did not set conflict flag");

  AST_MASTER_FAULT_ACTIONS: assert property (
    masterFault |=> !s_q.spOn && s_q.txEmpty && stateCounterClear && !spiOwnsPins)
    else $error("Master conflict actions missing");

  AST_SLAVE_KEEPS_ON: assert property (
    slaveFault && s_q.spOn && !access.ctrlWrite |=> s_q.spOn)
    else $error("Slave conflict changed port enable");

  AST_SLAVE_RISE_FAULT: assert property (
    slaveFault |=> s_q.conf ##1 s_q.xfer == smf_pkg::SMF_XF_IDLE)
    else $error("Slave deselect during transfer not flagged");

  AST_PHASE1_NO_START: assert property (
    s_q.xfer == smf_pkg::SMF_XF_IDLE && ctrl.clockPhaseSelect && sclkIdle |=>
      s_q.xfer == smf_pkg::SMF_XF_IDLE)
    else $error("Phase 1 transfer began without clock");

  AST_PHASE0_START: assert property (
    slaveOn && !ctrl.clockPhaseSelect && ssFall && s_q.xfer == smf_pkg::SMF_XF_IDLE
      |=> s_q.xfer == smf_pkg::SMF_XF_BUSY)
    else $error("Phase 0 select did not start transfer");

  AST_MISO_FLOAT: assert property (
    slaveSelectN |-> misoOeN)
    else $error("Data output driven while deselected");

  AST_CLEAR_SEQUENCE: assert property (
    $fell(s_q.conf) |-> $past(access.ctrlWrite) && $past(s_q.confArm)
      && !$past(s_q.confHit))
    else $error("Conflict flag cleared outside read-then-write");

  AST_TX_REQUEST: assert property (
    txIrq == (s_q.txEmpty && ctrl.txIrqEnable))
    else $error("Transmitter request mismatch");

  AST_RX_NEEDS_ON: assert property (
    rxErrIrq && !s_q.spOn |-> ctrl.errorIrqEnable && ctrl.rxIrqEnable)
    else $error("Receive request without port enable");

  AST_ERR_GATED: assert property (
    rxErrIrq && !s_q.rxFull |-> ctrl.rxIrqEnable && ctrl.errorIrqEnable)
    else $error("Error request without both enables");

  AST_BYTE_LOADS: assert property (
    slaveOn && step && cntNow == smf_pkg::CNT_BYTE && !s_q.discard |=>
      s_q.rxFull && rxData == $past(link.rxShift))
    else $error("Received byte not transferred");

  AST_OVERRUN_DROPS: assert property (
    slaveOn && step && cntNow == smf_pkg::CNT_BIT1 && s_q.rxFull |=>
      s_q.ovr ##[1:300] (s_q.discard == 1'b0))
    else $error("Overrun not flagged or byte not dropped");

  AST_TX_LOADS: assert property (
    startXfer && !s_q.txEmpty && !access.dataWrite |=> s_q.txEmpty
      && s_q.shiftSrc == $past(s_q.txBuf))
    else $error("Transmit byte not moved to shifter");

  AST_RX_REQUEST: assert property (
    s_q.rxFull && ctrl.rxIrqEnable && s_q.spOn |-> rxErrIrq)
    else $error("Receive-full request missing");

  AST_OVR_REQUEST: assert property (
    s_q.ovr && ctrl.rxIrqEnable && ctrl.errorIrqEnable |-> rxErrIrq)
    else $error("Overrun request missing");

  AST_CONF_REQUEST: assert property (
    s_q.conf && ctrl.rxIrqEnable && ctrl.errorIrqEnable && ctrl.roleConflictDetectEnable
      |-> rxErrIrq)
    else $error("Conflict request missing");

  AST_REQUEST_DROPS: assert property (
    !s_q.rxFull && !s_q.ovr && !s_q.conf |-> !rxErrIrq)
    else $error("Receiver/error request stands with no flag");

  AST_NO_SET_DISABLED: assert property (
    !ctrl.roleConflictDetectEnable && !s_q.conf |=> !s_q.conf)
    else $error("Conflict flag set while detection disabled");

  AST_DESELECT_IGNORES: assert property (
    slaveSelectN |-> link.cnt == smf_pkg::CNT_ZERO)
    else $error("Serial clock counted while deselected");

  AST_SLAVE_NO_CLEAR: assert property (
    slaveFault |=> !stateCounterClear)
    else $error("Slave conflict cleared the state counter");

  AST_PHASE1_START: assert property (
    slaveOn && ctrl.clockPhaseSelect && ssLow && !sclkIdle
      && s_q.xfer == smf_pkg::SMF_XF_IDLE |=> s_q.xfer == smf_pkg::SMF_XF_BUSY)
    else $error("Phase 1 transfer did not start on clock");

  COV_MASTER_FAULT: cover property (masterFault ##1 !s_q.spOn);
  COV_PHASE1_XFER: cover property (slaveOn && ctrl.clockPhaseSelect && s_q.xfer == smf_pkg::SMF_XF_BUSY);
  COV_SLAVE_FAULT: cover property (slaveFault ##1 rxErrIrq);
  COV_OVERRUN: cover property ($rose(s_q.ovr));
  COV_FLAG_CLEAR: cover property ($fell(s_q.conf));
endmodule
`default_nettype wire

// *** src/unused_placeholder_none.sv ***
// Intentionally empty of logic: keeps file list stable
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** dv/smf_master_model.sv ***
// Behavioural far-side master driving select, serial clock and serial data
`timescale 1ns/1ps
`default_nettype none
module smf_master_model (
  output logic slaveSelectN,
  output logic serialClockPin,
  output logic mosi
);
  initial begin
    slaveSelectN = 1'b1;
    serialClockPin = 1'b0;
    mosi = 1'b0;
  end

  // Clock stands idle low outside frames; data toggles after the last bit, before deselect
  task automatic sendBits(input logic clock_phase_select, input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      if (!clock_phase_select) mosi = b[7-i];
      #16 serialClockPin = 1'b1;
      if (clock_phase_select) mosi = b[7-i];
      #32 serialClockPin = 1'b0;
      #16;
    end
    mosi = ~mosi;
  endtask

  task automatic sel(input logic v);
    #20 slaveSelectN = v;
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the mode-fault and request logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk, rst, ssN, sck, mosi, misoOut, misoOeN, spiOwnsPins;
  logic stateCounterClear, txIrq, rxErrIrq, clrSeen;
  smf_pkg::smf_ctrl_t ctrl;
  smf_pkg::smf_access_t access;
  smf_pkg::smf_status_t status;
  logic [7:0] rxData;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  smf_core u_smf_core (.sys_clk(sys_clk), .rst(rst), .ctrl(ctrl), .access(access),
    .slaveSelectN(ssN), .serialClockPin(sck), .mosi(mosi), .misoOut(misoOut),
    .misoOeN(misoOeN), .status(status), .rxData(rxData), .spiOwnsPins(spiOwnsPins),
    .stateCounterClear(stateCounterClear), .txIrq(txIrq), .rxErrIrq(rxErrIrq));
  smf_master_model u_smf_master_model (.slaveSelectN(ssN), .serialClockPin(sck), .mosi(mosi));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (stateCounterClear === 1'b1) clrSeen <= 1'b1;
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic acc(input logic sr, cw, on, dr, dw, input logic [7:0] b);
    access = '{sr, cw, on, dr, dw, b};
    cyc(1);
    access = '0;
    cyc(1);
  endtask

  task automatic clr(input logic on);
    acc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    acc(1'b0, 1'b1, on, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic sel(input logic v, input int n);
    u_smf_master_model.sel(v);
    cyc(n);
  endtask

  // Port off, new controls, port on
  task automatic setup(input logic m, ph, det, err, rx, tx);
    acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    ctrl = '{m, ph, 1'b0, det, err, rx, tx};
    acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic testMaster();
    setup(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    clrSeen = 1'b0;
    chk(8'(spiOwnsPins), 8'h01);
    sel(1'b0, 8);
    chk(8'(status), 8'h09);
    chk(8'(spiOwnsPins), 8'h00);
    chk(8'(clrSeen), 8'h01);
    chk(8'(misoOeN), 8'h01);
    chk(8'(rxErrIrq), 8'h01);
    ctrl.errorIrqEnable = 1'b0;
    cyc(1);
    chk(8'(rxErrIrq), 8'h00);
    clr(1'b0);
    chk(8'(status.roleConflictFlag), 8'h01);
    ctrl.errorIrqEnable = 1'b1;
    ctrl.roleConflictDetectEnable = 1'b0;
    cyc(1);
    chk(8'(status.roleConflictFlag), 8'h01);
    chk(8'(rxErrIrq), 8'h00);
    sel(1'b1, 6);
    clr(1'b0);
    chk(8'(status.roleConflictFlag), 8'h00);
    sel(1'b0, 8);
    chk(8'(status.roleConflictFlag), 8'h00);
    sel(1'b1, 6);
  endtask

  task automatic testSlave();
    setup(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'ha5);
    chk(8'(txIrq), 8'h00);
    sel(1'b0, 6);
    chk(8'(status.txEmptyFlag), 8'h01);
    chk(8'(txIrq), 8'h01);
    chk(8'(misoOeN), 8'h00);
    chk(8'(misoOut), 8'h01);
    u_smf_master_model.sendBits(1'b0, 8'h3c, 8);
    cyc(8);
    sel(1'b1, 6);
    chk(rxData, 8'h3c);
    chk(8'(status), 8'h1c);
    chk(8'(misoOeN), 8'h01);
    chk(8'(rxErrIrq), 8'h01);
    acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    chk(8'(rxErrIrq), 8'h00);
    acc(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
    sel(1'b0, 6);
    u_smf_master_model.sendBits(1'b0, 8'hc3, 8);
    cyc(8);
    sel(1'b1, 6);
    chk(rxData, 8'h3c);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    chk(8'(status), 8'h1a);
    chk(8'(rxErrIrq), 8'h01);
    setup(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    chk(8'(rxErrIrq), 8'h00);
    acc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    chk(8'(status.rxOverrunFlag), 8'h00);
    u_smf_master_model.sendBits(1'b0, 8'hff, 8);
    cyc(8);
    chk(8'(status.rxFullFlag), 8'h00);
  endtask

  task automatic testNoClock();
    setup(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    sel(1'b0, 6);
    sel(1'b1, 6);
    chk(8'(status), 8'h19);
    chk(8'(rxErrIrq), 8'h01);
    clr(1'b1);
    chk(8'(status.roleConflictFlag), 8'h00);
    setup(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    sel(1'b0, 6);
    sel(1'b1, 6);
    chk(8'(status.roleConflictFlag), 8'h00);
    sel(1'b0, 6);
    u_smf_master_model.sendBits(1'b1, 8'hf0, 4);
    sel(1'b1, 6);
    chk(8'(status.roleConflictFlag), 8'h01);
  endtask

  initial begin
    rst = 1'b1;
    ctrl = '0;
    access = '0;
    clrSeen = 1'b0;
    repeat (2) @(posedge sys_clk);
    cyc(1);
    rst = 1'b0;
    cyc(1);
    chk(8'(status), 8'h08);
    chk(8'(misoOeN), 8'h01);
    testMaster();
    testSlave();
    testNoClock();
    summarize();
  end
endmodule
`default_nettype wire
